/* File: bench/memory_window_paging_test.sv */
// Self-checking bench for the memory window paging block
`timescale 1ns/1ps
`default_nettype none

module memory_window_paging_test;
  logic mclk, reset_n, ce, cfg_we, ram, rom, onq, actq;
  mwp_pkg::mwp_cfg_t cfg_in, cfg_q, cur;
  mwp_pkg::mwp_sel_t sel_q;
  logic [15:0] addr, rnd, rnd2;
  logic [12:0] lo_q;
  logic [2:0] hi_q, hi_oe_q;
  logic [5:0] gout, goe, gin, lvl, pout, poe;
  logic [18:0] mem;
  logic [34:0] notes[$];
  logic [34:0] nt, last_note;
  int fails, n_compared, cycles;

  mwp_pager dut_u (.mclk(mclk), .reset_n(reset_n), .ce(ce), .cfg_we(cfg_we),
    .cfg_in(cfg_in), .cfg_q(cfg_q), .cpu_addr(addr), .onchip_ram_hit(ram),
    .onchip_rom_hit(rom), .ext_addr_lo_q(lo_q), .cpu_hi_addr_q(hi_q),
    .cpu_hi_oe_q(hi_oe_q), .onchip_sel_q(onq), .window_active_q(actq), .sel_q(sel_q),
    .gpio_out(gout), .gpio_oe(goe), .gpio_in(gin), .pin_in(lvl), .pin_out(pout),
    .pin_oe(poe));
  mwp_mem_model mem_u (.mclk(mclk), .pin_out(pout), .pin_oe(poe), .lo_q(lo_q),
    .hi_q(hi_q), .hi_oe_q(hi_oe_q), .pin_level(lvl), .mem_addr(mem));

  // ----------------------------------------
  // Reference decode
  // ----------------------------------------
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic hit(logic [1:0] s, logic [2:0] b, logic [15:0] a);
    case (s)
      2'h1: return a[15:13] == b;
      2'h2: return a[15:14] == b[2:1];
      2'h3: return (b[2:1] == 2'h1) ? (a >= 16'h4000 && a < 16'hC000) : a[15] == b[2];
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [5:0] window_base_field(logic [1:0] s, logic [2:0] b, logic [5:0] k,
      logic [15:0] a);
    case (s)
      2'h1: return k;
      2'h2: return {k[5:1], a[13]};
      default: return {k[5:2], a[14] ^ (b[2:1] == 2'h1), a[13]};
    endcase
  endfunction
  function automatic logic [34:0] ref_note(mwp_pkg::mwp_cfg_t c, logic [15:0] a);
    logic [5:0] xa, po;
    logic [2:0] sl;
    xa = {3'h0, a[15:13]};
    sl = 3'h1;
    if (hit(c.window2_size_field, c.window2_base_field, a))
    begin
      xa = window_base_field(c.window2_size_field, c.window2_base_field, c.window2_bank_field, a);
      sl = 3'h4;
    end
    if (hit(c.window1_size_field, c.window1_base_field, a))
    begin
      xa = window_base_field(c.window1_size_field, c.window1_base_field, c.window1_bank_field, a);
      sl = 3'h2;
    end
    po = (c.pin_assign_reg & xa) | (~c.pin_assign_reg & gout);
    return {sl, ram | (rom & (sl == 3'h1 || xa[5:3] == 3'h0)), po, c.pin_assign_reg | goe,
      po[5:3], (c.pin_assign_reg[2:0] & xa[2:0]) | (~c.pin_assign_reg[2:0] & a[15:13]),
      a[12:0]};
  endfunction

  // ----------------------------------------
  // Drivers and checks
  // ----------------------------------------
  task automatic chk(string nm, logic [27:0] e, logic [27:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic load(mwp_pkg::mwp_cfg_t c);
    @(negedge mclk);
    ce = 1'b1;
    cfg_we = 1'b1;
    cfg_in = c;
    cur = c;
  endtask
  // Frozen cycle: outputs must hold, a load strobe must be ignored
  task automatic freeze();
    @(negedge mclk);
    ce = 1'b0;
    cfg_we = 1'b1;
    cfg_in = ~cur;
    addr = ~addr;
    notes.push_back(last_note);
  endtask
  task automatic step(logic [15:0] a);
    @(negedge mclk);
    rnd = lfsr(rnd);
    ce = 1'b1;
    cfg_we = 1'b0;
    addr = a;
    ram = rnd[0] & rnd[5];
    rom = rnd[1];
    gout = rnd[11:6];
    last_note = ref_note(cur, a);
    notes.push_back(last_note);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    #1;
    if (notes.size() > 0)
    begin
      nt = notes.pop_front();
      chk("sel_q", nt[34:32], sel_q);
      chk("window_active_q", nt[34:32] != 3'h1, actq);
      chk("onchip_sel_q", nt[31], onq);
      chk("pin_out", nt[30:25], pout);
      chk("pin_oe", nt[24:19], poe);
      chk("mem_addr", nt[18:0], mem);
    end
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    {fails, n_compared, cycles} = 0;
    rnd = 16'h000C;
    {reset_n, cfg_we, ram, rom} = 4'h0;
    ce = 1'b1;
    cfg_in = '0;
    cur = '0;
    {addr, gout, goe} = 28'h0;
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    chk("cfg_q", 28'h0, cfg_q);
    chk("cpu_hi_oe_q", 3'h7, hi_oe_q);
    // mid-based 32K window 1 overlapping 8K window 2
    load({6'h3F, 2'h3, 2'h1, 3'h2, 3'h2, 6'h2A, 6'h15});
    step(16'h3FFF);
    step(16'h4000);
    step(16'h5FFF);
    step(16'hBFFF);
    step(16'hC000);
    // random configs, base bits under the size are ignored
    repeat (60)
    begin
      rnd = lfsr(lfsr(rnd));
      rnd2 = lfsr(rnd);
      load({rnd, rnd2[11:0]});
      // Changed only after the last note of the previous config was checked
      goe = rnd[5:0];
      repeat (12) step(lfsr(rnd) ^ {rnd[7:0], rnd[15:8]});
      freeze();
    end
    load('0);
    goe = 6'h3F;
    step(16'h1234);
    repeat (3) @(negedge mclk);
    chk("gpio_in", gout, gin);
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: bench/mwp_mem_model.sv */
// External paged memory model on the shared expansion pins
`timescale 1ns/1ps
`default_nettype none

module mwp_mem_model (
  // Clock
  input wire logic mclk,
  // Pager pins
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [12:0] lo_q,
  input wire logic [2:0] hi_q,
  input wire logic [2:0] hi_oe_q,
  // Wire level and memory address
  output logic [5:0] pin_level,
  output logic [18:0] mem_addr
);
  logic [5:0] last_q;
  initial last_q = 6'h00;
  // No pull-up: a released pin flips so stale levels never pass
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~last_q);
  always @(posedge mclk)
  begin
    last_q <= pin_level;
  end
  // device address 14 wired to line 14, bank on upper lines
  assign mem_addr = {pin_out[5:3], (hi_oe_q & hi_q) | (~hi_oe_q & pin_out[2:0]), lo_q};
endmodule
`default_nettype wire

/* File: core/mwp_pager.sv */
// Memory window paging: bank expansion lines for a 16-bit CPU map
//
// Function
// R1: Two independent windows, each disabled or sized 8, 16 or 32 Kbytes.
// R2: Inside a window, expansion lines carry bank, low CPU bits carry offset.
// R3: Shared pin is expansion output only when its assign bit is set.
// R4: Used lower three expansion lines replace CPU address bits 15 to 13.
// R5: Offset uses bits 12:0, 13:0 or 14:0; bank lines start above it.
// R6: At most 64, 32 or 16 banks; lines reach bit 18.
// R7: Software places bases on size multiples; 32K may also start mid-map.
// R8: Mid-based 32K window drives inverted CPU bit 14 on line 14.
// R9: Memory wires its address 14 to expansion line 14 for mid-base.
// R10: Overlapping addresses belong to window 1.
// R11: Size code 00 off, 01 8K, 10 16K, 11 32K.
// R12: Bank register drives enabled lines inside its window; writes switch bank.
// R13: Three-bit base gives window start top bits; size masks low ones.
// R14: On-chip RAM repeats in every bank; ROM only where upper bits zero.
// R15: Outside windows, plain CPU address on shared upper lines, no bank.
`timescale 1ns/1ps
`default_nettype none
`include "mwp_regs.svh"

module mwp_pager (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Configuration load
  input wire logic cfg_we,
  input wire mwp_pkg::mwp_cfg_t cfg_in,
  output mwp_pkg::mwp_cfg_t cfg_q,
  // CPU access
  input wire logic [15:0] cpu_addr,
  input wire logic onchip_ram_hit,
  input wire logic onchip_rom_hit,
  // Address outputs
  output logic [12:0] ext_addr_lo_q,
  output logic [2:0] cpu_hi_addr_q,
  output logic [2:0] cpu_hi_oe_q,
  output logic onchip_sel_q,
  output logic window_active_q,
  output mwp_pkg::mwp_sel_t sel_q,
  // Shared port pins
  input wire logic [5:0] gpio_out,
  input wire logic [5:0] gpio_oe,
  output logic [5:0] gpio_in,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  mwp_pkg::mwp_cfg_t cfg_d;

  always_comb
  begin
    cfg_d = cfg_q;
    // R12: new bank visible from next access
    if (cfg_we)
    begin
      cfg_d = cfg_in;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cfg_q <= '{`MWP_PIN_ASSIGN_RST, `MWP_SIZE_RST, `MWP_SIZE_RST,
                 `MWP_BASE_RST, `MWP_BASE_RST, `MWP_BANK_RST, `MWP_BANK_RST};
    end
    else if (ce)
    begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------
  // Window decode
  // ----------------------------------------
  logic hit1;
  logic hit2;
  logic mid1;
  logic mid2;
  logic [5:0] xa1;
  logic [5:0] xa2;

  // R1: two independent windows
  mwp_window_decode u_win1 (
    .size_field(cfg_q.window1_size_field),
    .base_field(cfg_q.window1_base_field),
    .bank_field(cfg_q.window1_bank_field),
    .cpu_addr(cpu_addr),
    .hit(hit1),
    .mid_base(mid1),
    .xa(xa1)
  );

  mwp_window_decode u_win2 (
    .size_field(cfg_q.window2_size_field),
    .base_field(cfg_q.window2_base_field),
    .bank_field(cfg_q.window2_bank_field),
    .cpu_addr(cpu_addr),
    .hit(hit2),
    .mid_base(mid2),
    .xa(xa2)
  );

  // ----------------------------------------
  // Address formation
  // ----------------------------------------
  logic [5:0] xa_d;
  logic [5:0] xa_q;
  logic [12:0] lo_d;
  logic [2:0] hi_d;
  logic [2:0] hi_oe_d;
  logic onchip_d;
  logic active_d;
  mwp_pkg::mwp_sel_t sel_d;

  always_comb
  begin
    // R15: plain CPU address, no bank, outside windows
    xa_d = {3'h0, cpu_addr[15:13]};
    sel_d = mwp_pkg::MWP_SEL_NONE;
    // R10: window 1 wins overlaps
    if (hit1)
    begin
      // R2: bank on expansion lines
      xa_d = xa1;
      sel_d = mwp_pkg::MWP_SEL_W1;
    end
    else if (hit2)
    begin
      xa_d = xa2;
      sel_d = mwp_pkg::MWP_SEL_W2;
    end
    active_d = hit1 | hit2;
    // R2: low CPU bits pass as offset
    lo_d = cpu_addr[12:0];
    hi_d = cpu_addr[15:13];
    // R4: assigned low lines take over CPU bits 15:13
    hi_oe_d = ~cfg_q.pin_assign_reg[2:0];
    // R14: RAM in all banks, ROM only in bank group zero
    onchip_d = onchip_ram_hit |
               (onchip_rom_hit & (!active_d | (xa_d[5:3] == `MWP_ROM_BANK_ZERO)));
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      xa_q <= 6'h00;
      ext_addr_lo_q <= 13'h0000;
      cpu_hi_addr_q <= 3'h0;
      cpu_hi_oe_q <= 3'h7;
      onchip_sel_q <= 1'b0;
      window_active_q <= 1'b0;
      sel_q <= mwp_pkg::MWP_SEL_NONE;
    end
    else if (ce)
    begin
      xa_q <= xa_d;
      ext_addr_lo_q <= lo_d;
      cpu_hi_addr_q <= hi_d;
      cpu_hi_oe_q <= hi_oe_d;
      onchip_sel_q <= onchip_d;
      window_active_q <= active_d;
      sel_q <= sel_d;
    end
  end

  // ----------------------------------------
  // Shared pins
  // ----------------------------------------
  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;

  // Pin levels are asynchronous, hence two stages
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
    end
    else if (ce)
    begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  always_comb
  begin
    gpio_in = pin_sync_q;
    // R3: assign bit picks expansion or general use
    pin_out = (cfg_q.pin_assign_reg & xa_q) | (~cfg_q.pin_assign_reg & gpio_out);
    pin_oe = cfg_q.pin_assign_reg | gpio_oe;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  pin_gpio_pass_a: assert property (pin_out == ((cfg_q.pin_assign_reg & xa_q) | // R3
    (~cfg_q.pin_assign_reg & gpio_out)) && ((cfg_q.pin_assign_reg & ~pin_oe) == 6'h00))
    else $error("pin mux wrong");

  win1_bank_out_a: assert property (ce && hit1 && cfg_q.window1_size_field == // R12
    `MWP_SIZE_8K |=> xa_q == $past(cfg_q.window1_bank_field))
    else $error("window 1 bank not driven");

  win_priority_a: assert property (ce && hit1 && hit2 |=> // R10
    sel_q == mwp_pkg::MWP_SEL_W1)
    else $error("window 2 won an overlap");

  outside_plain_a: assert property (ce && !hit1 && !hit2 |=> // R15
    xa_q == {3'h0, $past(cpu_addr[15:13])} && !window_active_q)
    else $error("bank leaked outside windows");

  mid_inv_a: assert property (ce && hit1 && mid1 && // R8
    cfg_q.window1_size_field == `MWP_SIZE_32K |=> xa_q[1] == !$past(cpu_addr[14]))
    else $error("bit 14 not inverted");

  offset_16k_a: assert property (ce && hit2 && !hit1 && // R5
    cfg_q.window2_size_field == `MWP_SIZE_16K |=> xa_q[0] == $past(cpu_addr[13])
    && xa_q[5:1] == $past(cfg_q.window2_bank_field[5:1]))
    else $error("16K offset split wrong");

  size_off_a: assert property (cfg_q.window1_size_field == `MWP_SIZE_OFF |-> !hit1) // R11
    else $error("disabled window hit");

  base_match_a: assert property (cfg_q.window2_size_field == `MWP_SIZE_8K && // R13
    cpu_addr[15:13] != cfg_q.window2_base_field |-> !hit2)
    else $error("8K base mismatch hit");

  rom_bank_a: assert property (ce && onchip_rom_hit && !onchip_ram_hit && hit1 && // R14
    xa1[5:3] != 3'h0 |=> !onchip_sel_q)
    else $error("ROM seen in upper bank");

  hi_replace_a: assert property (ce ##1 ce |-> // R4
    cpu_hi_oe_q == ~$past(cfg_q.pin_assign_reg[2:0]))
    else $error("CPU high bits not replaced");

  bank_switch_c: cover property (ce && cfg_we ##1 ce && hit1 ##1 ce);
  overlap_c: cover property (ce && hit1 && hit2);
  mid_base_c: cover property (ce && hit2 && mid2 && !hit1);
  rom_bank0_c: cover property (ce && onchip_rom_hit && hit1 ##1 onchip_sel_q);

endmodule
`default_nettype wire

/* File: core/mwp_pkg.sv */
// Types shared by the memory window paging block
package mwp_pkg;

  // ----------------------------------------
  // Configuration carrier
  // ----------------------------------------
  typedef struct packed {
    logic [5:0] pin_assign_reg;
    logic [1:0] window1_size_field;
    logic [1:0] window2_size_field;
    logic [2:0] window1_base_field;
    logic [2:0] window2_base_field;
    logic [5:0] window1_bank_field;
    logic [5:0] window2_bank_field;
  } mwp_cfg_t;

  // ----------------------------------------
  // Window selected for the current access, one-hot
  // ----------------------------------------
  typedef enum logic [2:0] {
    MWP_SEL_NONE = 3'h1,
    MWP_SEL_W1 = 3'h2,
    MWP_SEL_W2 = 3'h4
  } mwp_sel_t;

endpackage

/* File: core/mwp_regs.svh */
// Constants for the memory window paging block
`ifndef MWP_REGS_SVH
`define MWP_REGS_SVH

// ----------------------------------------
// Field widths
// ----------------------------------------
`define MWP_XA_W 6
`define MWP_SIZE_W 2
`define MWP_BASE_W 3

// ----------------------------------------
// Window size codes
// ----------------------------------------
`define MWP_SIZE_OFF 2'h0
`define MWP_SIZE_8K 2'h1
`define MWP_SIZE_16K 2'h2
`define MWP_SIZE_32K 2'h3

// ----------------------------------------
// Base codes and reset values
// ----------------------------------------
`define MWP_BASE_32K_MID_HI 2'h1
`define MWP_PIN_ASSIGN_RST 6'h00
`define MWP_SIZE_RST 2'h0
`define MWP_BASE_RST 3'h0
`define MWP_BANK_RST 6'h00
`define MWP_ROM_BANK_ZERO 3'h0

`endif

/* File: core/mwp_window_decode.sv */
// One window: address match and expansion line value
`timescale 1ns/1ps
`default_nettype none
`include "mwp_regs.svh"

module mwp_window_decode (
  // Window configuration
  input wire logic [1:0] size_field,
  input wire logic [2:0] base_field,
  input wire logic [5:0] bank_field,
  // CPU address
  input wire logic [15:0] cpu_addr,
  // Decode results
  output logic hit,
  output logic mid_base,
  output logic [5:0] xa
);

  always_comb
  begin
    hit = 1'b0;
    mid_base = 1'b0;
    // R6: six bank lines, reaching XA18
    xa = bank_field;
    case (size_field)
      // R11: size code decode
      `MWP_SIZE_OFF:
      begin
        hit = 1'b0;
      end
      // R13: base uses top bits only
      `MWP_SIZE_8K:
      begin
        hit = (cpu_addr[15:13] == base_field);
      end
      `MWP_SIZE_16K:
      begin
        hit = (cpu_addr[15:14] == base_field[2:1]);
        // R5: offset takes bit 13
        xa[0] = cpu_addr[13];
      end
      `MWP_SIZE_32K:
      begin
        mid_base = (base_field[2:1] == `MWP_BASE_32K_MID_HI);
        // R7: mid base spans the two centre quarters
        hit = mid_base ? (cpu_addr[15] != cpu_addr[14]) : (cpu_addr[15] == base_field[2]);
        xa[0] = cpu_addr[13];
        // R8: inverted bit 14 for mid base
        xa[1] = mid_base ? ~cpu_addr[14] : cpu_addr[14];
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire
